/* File: btp_consts.svh */
// Constants for the branch target cache and predictor block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef BTP_CONSTS_SVH
`define BTP_CONSTS_SVH

// ==========================================================================
// Geometry
`define BTP_ADDR_W      22
`define BTP_SETS        32
`define BTP_SET_W       5
`define BTP_SET_LSB     2
`define BTP_WAYS        4
`define BTP_TAG_HI_LSB  7
`define BTP_TAG_W       17
`define BTP_QW_LOCS     4
`define BTP_QW_STEP     22'h000004

// ==========================================================================
// Replacement recency codes
`define BTP_REC_W       3
`define BTP_REC_INVALID 3'h0
`define BTP_REC_OLDEST  3'h1
`define BTP_REC_MRU     3'h6
`define BTP_REC_LOCKED  3'h7

// ==========================================================================
// Penalty cycle counts
`define BTP_PEN_W       3
`define BTP_PEN_MISS    3'h2
`define BTP_PEN_INT     3'h3
`define BTP_PEN_COMP    3'h6
`define BTP_PEN_CROSS   3'h1

`endif

/* File: btp_pkg.sv */
// Types shared by the branch target cache and predictor block.
// Assumes btp_consts.svh is on the include path.
`include "btp_consts.svh"

package btp_pkg;

  // ========================================================================
  // Condition classes and the stage that resolves them
  typedef enum logic [2:0] {
    COND_INTEGER, COND_COMPUTE, COND_EXTERNAL, COND_TRUE, COND_BUS_MASTER
  } btp_cond_type;

  typedef enum logic {STAGE_INTEGER, STAGE_EXECUTE_TWO} btp_stage_type;

  typedef enum logic {ST_RUN, ST_STALL} btp_fsm_type;

  // ========================================================================
  // Decode stage report of a branch
  typedef struct packed {
    logic                    valid;
    logic                    is_branch;
    logic                    not_predicted_option;
    logic                    hit;
    logic                    computed_jump;
    logic                    interrupt_return;
    logic [`BTP_ADDR_W-1:0]  hit_target;
    logic [`BTP_ADDR_W-1:0]  line_end_addr;
    logic [`BTP_ADDR_W-1:0]  target;
    logic                    target_cross;
  } btp_decode_type;

  // ========================================================================
  // Condition resolution report
  typedef struct packed {
    logic                    valid;
    logic                    predicted_taken;
    logic                    taken;
    btp_stage_type           stage;
    logic [`BTP_ADDR_W-1:0]  target;
    logic [`BTP_ADDR_W-1:0]  seq_addr;
    logic                    target_cross;
    logic                    seq_cross;
  } btp_resolve_type;

  // ========================================================================
  // Whole state of the predictor
  typedef struct packed {
    logic [`BTP_WAYS-1:0][`BTP_SETS-1:0][`BTP_TAG_W-1:0]   tag;
    logic [`BTP_WAYS-1:0][`BTP_SETS-1:0][`BTP_ADDR_W-1:0]  target;
    logic [`BTP_WAYS-1:0][`BTP_SETS-1:0]                   cjump;
    logic [`BTP_WAYS-1:0][`BTP_SETS-1:0]                   iret;
    logic [`BTP_WAYS-1:0][`BTP_SETS-1:0][`BTP_REC_W-1:0]   rec;
    btp_fsm_type                                            fsm;
    logic [`BTP_PEN_W-1:0]                                  stall_cnt;
    logic [`BTP_ADDR_W-1:0]                                 fetch_pc;
    logic                                                   redirect;
    logic [`BTP_PEN_W-1:0]                                  discard;
  } btp_state_type;

endpackage

/* File: btp_predictor.sv */
// Branch target cache lookup, decode redirect, fill and misprediction recovery.
// Assumes fetch, decode and condition stages on the same clock report in order.
//
// Operation
// - Enabled: compare fetch address with tags in fetch stage one; hit loads target.
// - Branch that hit reaches decode: no further redirect.
// - Predicted branch missed: discard two fetched instructions, redirect to target.
// - After a miss redirect, write the target into the cache.
// - Fetch one aligned quad word of four locations at a time.
// - One entry per aligned quad word, tagged by line-end quad word.
// - Computed jump hit uses its register; a later change forces miss flow.
// - Branches predicted taken unless they carry the not-predicted option.
// - Predicted-taken branch enters the cache; decode fetches its target regardless.
// - Only predicted-taken branches allocate entries.
// - Integer conditions resolve at integer stage; compute ones at execute two.
// - External and true conditions at integer; bus-master at execute two.
// - No penalty for correct not-taken or hit-and-taken branches.
// - Two lost cycles for predicted taken, cache miss, actually taken.
// - Mispredict discards stages: three cycles integer, six cycles compute.
// - One more cycle when taken target line crosses a quad word.
// - One more cycle when wrongly predicted taken and sequential line crosses.
// - Thirty-two sets of four ways, set chosen by five address bits.
// - Three-bit recency: zero invalid, one to six recency, seven locked.
// - Cache disabled: every lookup misses, static prediction still steers fetch.
`timescale 1ns/1ps
`include "btp_consts.svh"

module btp_predictor #(
  parameter int SETS = `BTP_SETS,
  parameter int WAYS = `BTP_WAYS
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Control.
  input  wire logic                    target_cache_enable,
  input  wire logic                    invalidate_all,
  input  wire logic [`BTP_ADDR_W-1:0]  restart_addr,
  input  wire logic                    restart,
  // Fetch stage one.
  input  wire logic                    fetch_stage_one_valid,
  output logic                         fetch_stage_one_hit,
  output logic [`BTP_ADDR_W-1:0]       fetch_stage_one_hit_target,
  output logic                         fetch_stage_one_hit_cjump,
  output logic                         fetch_stage_one_hit_iret,
  output logic                         fetch_go,
  output logic [`BTP_ADDR_W-1:0]       fetch_addr,
  // Computed target registers.
  input  wire logic [`BTP_ADDR_W-1:0]  computed_jump_target_reg,
  input  wire logic [`BTP_ADDR_W-1:0]  interrupt_return_target_reg,
  // Decode and resolution reports.
  input  wire btp_pkg::btp_decode_type  dec,
  input  wire btp_pkg::btp_resolve_type res,
  input  wire btp_pkg::btp_cond_type    cond_class,
  output btp_pkg::btp_stage_type        cond_resolve_stage,
  // Pipeline discard.
  output logic                         redirect,
  output logic [`BTP_PEN_W-1:0]        discard_cycles
);

  // ========================================================================
  // Elaboration check
  if (SETS != `BTP_SETS || WAYS != `BTP_WAYS) begin : g_bad_geometry
    $error("btp_predictor serves only 32 sets of 4 ways");
  end

  // ========================================================================
  // State
  btp_pkg::btp_state_type s_q;
  btp_pkg::btp_state_type s_d;

  logic [`BTP_SET_W-1:0]   look_set;
  logic [`BTP_TAG_W-1:0]   look_tag;
  logic [`BTP_WAYS-1:0]    way_match;
  logic [`BTP_SET_W-1:0]   fill_set;
  logic [`BTP_TAG_W-1:0]   fill_tag;
  logic [`BTP_WAYS-1:0]    fill_match;

  // Set from address bits six to two; tag from bits 21..7 and 1..0.
  assign look_set = s_q.fetch_pc[`BTP_SET_LSB +: `BTP_SET_W];
  assign look_tag = {s_q.fetch_pc[`BTP_ADDR_W-1:`BTP_TAG_HI_LSB], 2'h0};
  assign fill_set = dec.line_end_addr[`BTP_SET_LSB +: `BTP_SET_W];
  assign fill_tag = {dec.line_end_addr[`BTP_ADDR_W-1:`BTP_TAG_HI_LSB],
                     dec.line_end_addr[1:0]};

  // Fetch addresses are quad-word aligned, so only the upper tag bits decide
  // a hit; the low two bits only record where the line ends.
  for (genvar w = 0; w < `BTP_WAYS; w++) begin : g_way
    assign way_match[w] = (s_q.rec[w][look_set] != `BTP_REC_INVALID) &&
                          (s_q.tag[w][look_set][`BTP_TAG_W-1:2] ==
                           look_tag[`BTP_TAG_W-1:2]);
    assign fill_match[w] = (s_q.rec[w][fill_set] != `BTP_REC_INVALID) &&
                           (s_q.tag[w][fill_set] == fill_tag);
  end

  // ========================================================================
  // Condition class to resolving stage
  always_comb begin
    case (cond_class)
      btp_pkg::COND_COMPUTE:    cond_resolve_stage = btp_pkg::STAGE_EXECUTE_TWO;
      btp_pkg::COND_BUS_MASTER: cond_resolve_stage = btp_pkg::STAGE_EXECUTE_TWO;
      default:                  cond_resolve_stage = btp_pkg::STAGE_INTEGER;
    endcase
  end

  // ========================================================================
  // Next state
  logic                     hit;
  logic [1:0]               hit_way;
  logic [`BTP_ADDR_W-1:0]   hit_tgt;
  logic                     predicted;
  logic                     cjump_stale;
  logic [1:0]               fill_way;
  logic                     fill_ok;
  logic                     dec_miss;
  logic                     mispredict;
  logic [1:0]               victim;
  logic                     victim_ok;
  logic [`BTP_REC_W-1:0]    victim_rec;
  logic [`BTP_PEN_W-1:0]    pen;
  logic [`BTP_REC_W-1:0]    old_rec;

  always_comb begin
    s_d        = s_q;
    hit        = 1'b0;
    hit_way    = 2'h0;
    hit_tgt    = '0;
    victim     = 2'h0;
    victim_ok  = 1'b0;
    victim_rec = `BTP_REC_LOCKED;
    pen        = '0;
    old_rec    = '0;
    s_d.redirect = 1'b0;
    s_d.discard  = '0;

    // Lookup in fetch stage one; a disabled cache always misses.
    for (int w = 0; w < `BTP_WAYS; w++) begin
      if (!hit && way_match[w] && target_cache_enable) begin
        hit     = 1'b1;
        hit_way = w[1:0];
      end
    end
    if (s_q.cjump[hit_way][look_set]) begin
      hit_tgt = computed_jump_target_reg;
    end else if (s_q.iret[hit_way][look_set]) begin
      hit_tgt = interrupt_return_target_reg;
    end else begin
      hit_tgt = s_q.target[hit_way][look_set];
    end

    predicted  = !dec.not_predicted_option;
    cjump_stale = dec.hit && (
                 (dec.computed_jump && dec.hit_target != computed_jump_target_reg) ||
                 (dec.interrupt_return &&
                  dec.hit_target != interrupt_return_target_reg));
    dec_miss   = dec.valid && dec.is_branch && predicted &&
                 (!dec.hit || cjump_stale);
    mispredict = res.valid && (res.predicted_taken != res.taken);

    // Victim choice: invalid first, else lowest unlocked recency.
    for (int w = 0; w < `BTP_WAYS; w++) begin
      if (s_q.rec[w][fill_set] < victim_rec) begin
        victim_rec = s_q.rec[w][fill_set];
        victim     = w[1:0];
        victim_ok  = 1'b1;
      end
    end
    // An entry that already holds this branch's full tag is refreshed in place, not reallocated.
    fill_way = victim;
    fill_ok  = victim_ok;
    for (int w = 0; w < `BTP_WAYS; w++) begin
      if (fill_match[w]) begin
        fill_way = w[1:0];
        fill_ok  = 1'b1;
      end
    end

    case (s_q.fsm)
      btp_pkg::ST_RUN: begin
        if (fetch_stage_one_valid) begin
          if (hit) begin
            s_d.fetch_pc = hit_tgt;
            old_rec = s_q.rec[hit_way][look_set];
            for (int w = 0; w < `BTP_WAYS; w++) begin
              if (w[1:0] == hit_way) begin
                if (old_rec != `BTP_REC_LOCKED) begin
                  s_d.rec[w][look_set] = `BTP_REC_MRU;
                end
              end else if (s_q.rec[w][look_set] > old_rec &&
                           s_q.rec[w][look_set] != `BTP_REC_LOCKED &&
                           s_q.rec[w][look_set] > `BTP_REC_OLDEST) begin
                s_d.rec[w][look_set] = s_q.rec[w][look_set] - `BTP_REC_OLDEST;
              end
            end
          end else begin
            s_d.fetch_pc = {s_q.fetch_pc[`BTP_ADDR_W-1:2], 2'h0} + `BTP_QW_STEP;
          end
        end
      end
      btp_pkg::ST_STALL: begin
        s_d.stall_cnt = s_q.stall_cnt - `BTP_PEN_CROSS;
        if (s_q.stall_cnt == `BTP_PEN_CROSS) begin
          s_d.fsm = btp_pkg::ST_RUN;
        end
      end
      default: s_d.fsm = btp_pkg::ST_RUN;
    endcase

    // The older instruction at resolution wins over a younger one at decode.
    if (mispredict) begin
      if (res.stage == btp_pkg::STAGE_EXECUTE_TWO) begin
        pen = `BTP_PEN_COMP;
      end else begin
        pen = `BTP_PEN_INT;
      end
      if (res.taken) begin
        s_d.fetch_pc = res.target;
        if (res.target_cross) begin
          pen = pen + `BTP_PEN_CROSS;
        end
      end else begin
        s_d.fetch_pc = res.seq_addr;
        if (res.seq_cross) begin
          pen = pen + `BTP_PEN_CROSS;
        end
      end
    end else if (dec_miss) begin
      pen = `BTP_PEN_MISS;
      s_d.fetch_pc = dec.target;
      if (dec.target_cross) begin
        pen = pen + `BTP_PEN_CROSS;
      end
      // The fill ages the unlocked ways more recent than the filled one, so the next miss still finds the oldest one.
      if (target_cache_enable && fill_ok) begin
        old_rec = s_q.rec[fill_way][fill_set];
        for (int w = 0; w < `BTP_WAYS; w++) begin
          if (w[1:0] == fill_way) begin
            s_d.tag[w][fill_set]    = fill_tag;
            s_d.target[w][fill_set] = dec.target;
            s_d.cjump[w][fill_set]  = dec.computed_jump;
            s_d.iret[w][fill_set]   = dec.interrupt_return;
            if (old_rec != `BTP_REC_LOCKED) begin
              s_d.rec[w][fill_set]  = `BTP_REC_MRU;
            end
          end else if (s_q.rec[w][fill_set] > old_rec &&
                       s_q.rec[w][fill_set] != `BTP_REC_LOCKED &&
                       s_q.rec[w][fill_set] > `BTP_REC_OLDEST) begin
            s_d.rec[w][fill_set] = s_q.rec[w][fill_set] - `BTP_REC_OLDEST;
          end
        end
      end
    end
    // Correct not-taken and hit-and-taken paths leave pen at zero.
    if (pen != '0) begin
      s_d.redirect  = 1'b1;
      s_d.discard   = pen;
      s_d.stall_cnt = pen;
      s_d.fsm       = btp_pkg::ST_STALL;
    end

    if (restart) begin
      s_d.fetch_pc  = restart_addr;
      s_d.fsm       = btp_pkg::ST_RUN;
      s_d.stall_cnt = '0;
      s_d.redirect  = 1'b0;
      s_d.discard   = '0;
    end
    // Invalidation clears locked ways too, as overlays make them stale.
    if (invalidate_all) begin
      s_d.rec = '0;
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  assign fetch_stage_one_hit        = hit && fetch_stage_one_valid;
  assign fetch_stage_one_hit_target = hit_tgt;
  assign fetch_stage_one_hit_cjump  = s_q.cjump[hit_way][look_set];
  assign fetch_stage_one_hit_iret   = s_q.iret[hit_way][look_set];
  assign fetch_go                   = (s_q.fsm == btp_pkg::ST_RUN);
  assign fetch_addr                 = s_q.fetch_pc;
  assign redirect                   = s_q.redirect;
  assign discard_cycles             = s_q.discard;

endmodule

/* File: btp_predictor_sva.sv */
// Concurrent checks on the ports of the branch predictor.
// Assumes one clock domain and the port names of btp_predictor.
`timescale 1ns/1ps
`include "btp_consts.svh"

module btp_predictor_sva #(
  parameter int SETS = `BTP_SETS,
  parameter int WAYS = `BTP_WAYS
) (
  // Clock and reset.
  input wire logic                     clk,
  input wire logic                     rstn,
  // Control and fetch.
  input wire logic                     target_cache_enable,
  input wire logic                     restart,
  input wire logic                     fetch_stage_one_valid,
  input wire logic                     fetch_stage_one_hit,
  input wire logic [`BTP_ADDR_W-1:0]   fetch_stage_one_hit_target,
  input wire logic                     fetch_stage_one_hit_cjump,
  input wire logic                     fetch_go,
  input wire logic [`BTP_ADDR_W-1:0]   fetch_addr,
  input wire logic [`BTP_ADDR_W-1:0]   computed_jump_target_reg,
  // Reports and results.
  input wire btp_pkg::btp_decode_type  dec,
  input wire btp_pkg::btp_resolve_type res,
  input wire btp_pkg::btp_cond_type    cond_class,
  input wire btp_pkg::btp_stage_type   cond_resolve_stage,
  input wire logic                     redirect,
  input wire logic [`BTP_PEN_W-1:0]    discard_cycles
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Fetch stage one and condition stage map
  disabled_miss_a: assert property (!target_cache_enable |-> !fetch_stage_one_hit)
    else $error("hit while cache disabled");
  hit_valid_a: assert property (fetch_stage_one_hit |-> fetch_stage_one_valid)
    else $error("hit without fetch");
  hit_follow_a: assert property (fetch_go && fetch_stage_one_valid && fetch_stage_one_hit
    && !restart && !dec.valid && !res.valid |=> fetch_addr == $past(fetch_stage_one_hit_target))
    else $error("hit did not steer fetch");
  seq_step_a: assert property (fetch_go && fetch_stage_one_valid && !fetch_stage_one_hit
    && !restart && !dec.valid && !res.valid
    |=> fetch_addr == ($past(fetch_addr) & 22'h3FFFFC) + `BTP_QW_STEP)
    else $error("sequential quad word step wrong");
  cjump_target_a: assert property (fetch_stage_one_hit && fetch_stage_one_hit_cjump
    |-> fetch_stage_one_hit_target == computed_jump_target_reg)
    else $error("computed jump hit target wrong");
  stage_map_a: assert property (cond_resolve_stage == ((cond_class == btp_pkg::COND_COMPUTE
    || cond_class == btp_pkg::COND_BUS_MASTER) ? btp_pkg::STAGE_EXECUTE_TWO
    : btp_pkg::STAGE_INTEGER))
    else $error("condition stage map wrong");

  // ==========================================================================
  // Decode and resolution
  miss_redirect_a: assert property (fetch_go && dec.valid && dec.is_branch
    && !dec.not_predicted_option && !dec.hit && !res.valid && !restart
    |=> redirect && discard_cycles == `BTP_PEN_MISS + $past(dec.target_cross)
    && fetch_addr == $past(dec.target))
    else $error("miss redirect wrong");
  hit_quiet_a: assert property (dec.valid && dec.is_branch && dec.hit
    && !dec.computed_jump && !dec.interrupt_return && !res.valid && !restart |=> !redirect)
    else $error("redirect after hit");
  nopred_quiet_a: assert property (dec.valid && dec.not_predicted_option
    && !res.valid && !restart |=> !redirect)
    else $error("redirect on not predicted branch");
  mispredict_cost_a: assert property (res.valid && res.predicted_taken != res.taken
    && !restart |=> redirect && discard_cycles == (($past(res.stage)
    == btp_pkg::STAGE_EXECUTE_TWO ? `BTP_PEN_COMP : `BTP_PEN_INT)
    + ($past(res.taken) ? $past(res.target_cross) : $past(res.seq_cross))))
    else $error("mispredict penalty wrong");
  redirect_stall_a: assert property (redirect |-> !fetch_go)
    else $error("fetch not stalled on redirect");
endmodule

bind btp_predictor btp_predictor_sva #(.SETS(SETS), .WAYS(WAYS)) u_sva (.clk, .rstn,
  .target_cache_enable, .restart, .fetch_stage_one_valid, .fetch_stage_one_hit,
  .fetch_stage_one_hit_target, .fetch_stage_one_hit_cjump, .fetch_go, .fetch_addr,
  .computed_jump_target_reg, .dec, .res, .cond_class, .cond_resolve_stage, .redirect,
  .discard_cycles);

/* File: btp_pipe_model.sv */
// Fetch-to-decode partner: carries the stage one hit forward into the decode report.
// Assumes the bench hands it one branch request at a time on the core clock.
`timescale 1ns/1ps
`include "btp_consts.svh"

module btp_pipe_model (
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    rstn,
  // Fetch stage one.
  input wire logic                    fetch_stage_one_valid,
  input wire logic                    fetch_go,
  input wire logic                    fetch_stage_one_hit,
  input wire logic [`BTP_ADDR_W-1:0]  fetch_stage_one_hit_target,
  // Branch request and decode report.
  input wire btp_pkg::btp_decode_type br,
  output btp_pkg::btp_decode_type     dec
);
  logic                   hit_q;
  logic [`BTP_ADDR_W-1:0] tgt_q;
  logic [71:0]            pat_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hit_q <= 1'b0;
      tgt_q <= 22'h000000;
      pat_q <= 72'h5A5A5A5A5A5A5A5A5A;
    end else begin
      pat_q <= ~pat_q;
      if (fetch_go && fetch_stage_one_valid) begin
        hit_q <= fetch_stage_one_hit;
        tgt_q <= fetch_stage_one_hit_target;
      end
    end
  end

  // Idle report lines toggle, so a design that reads them outside a report is caught.
  always_comb begin
    dec = br.valid ? br : btp_pkg::btp_decode_type'({1'b0, pat_q});
    if (br.valid) begin
      dec.hit = hit_q;
      dec.hit_target = tgt_q;
    end
  end
endmodule

/* File: btp_predictor_bench.sv */
// Self-checking bench for the branch predictor.
// Assumes btp_pipe_model as the fetch and decode partner.
`timescale 1ns/1ps
`include "btp_consts.svh"

module btp_predictor_bench;
  localparam int LIMIT = 5000;
  logic                     clk, rstn, target_cache_enable, invalidate_all, restart;
  logic                     fetch_stage_one_valid, fetch_stage_one_hit, hit_cjump, hit_iret;
  logic                     fetch_go, redirect;
  logic [`BTP_ADDR_W-1:0]   restart_addr, hit_target, fetch_addr, cjump_reg, iret_reg;
  logic [`BTP_ADDR_W-1:0]   tg [5];
  logic [`BTP_PEN_W-1:0]    discard_cycles;
  logic [48:0]              noise;
  btp_pkg::btp_decode_type  br, dec;
  btp_pkg::btp_resolve_type rq, res;
  btp_pkg::btp_cond_type    cond_class;
  btp_pkg::btp_stage_type   stage;
  int                       n_mismatch, checks_done, cycles;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) noise <= ~noise;
  assign res = rq.valid ? rq : btp_pkg::btp_resolve_type'({1'b0, noise});

  btp_predictor dut (.clk(clk), .rstn(rstn), .target_cache_enable(target_cache_enable),
    .invalidate_all(invalidate_all), .restart_addr(restart_addr), .restart(restart),
    .fetch_stage_one_valid(fetch_stage_one_valid), .fetch_stage_one_hit(fetch_stage_one_hit),
    .fetch_stage_one_hit_target(hit_target), .fetch_stage_one_hit_cjump(hit_cjump),
    .fetch_stage_one_hit_iret(hit_iret), .fetch_go(fetch_go), .fetch_addr(fetch_addr),
    .computed_jump_target_reg(cjump_reg), .interrupt_return_target_reg(iret_reg), .dec(dec),
    .res(res), .cond_class(cond_class), .cond_resolve_stage(stage), .redirect(redirect),
    .discard_cycles(discard_cycles));
  btp_pipe_model partner (.clk(clk), .rstn(rstn), .fetch_stage_one_valid(fetch_stage_one_valid),
    .fetch_go(fetch_go), .fetch_stage_one_hit(fetch_stage_one_hit),
    .fetch_stage_one_hit_target(hit_target), .br(br), .dec(dec));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end
  // Every test branch owns its own aligned quad word.
  function automatic logic [21:0] qaddr(input int t, input int s);
    return {t[14:0], s[4:0], 2'h0};
  endfunction
  function automatic logic [21:0] rnd_qw();
    return 22'($urandom()) & 22'h3FFFFC;
  endfunction
  function automatic btp_pkg::btp_decode_type mkbr(input logic [21:0] a, t,
                                                   input logic nopred, cj, tc);
    return '{1'b1, 1'b1, nopred, 1'b0, cj, 1'b0, 22'h0, a, t, tc};
  endfunction
  function automatic logic [2:0] res_cost(input btp_pkg::btp_resolve_type r);
    res_cost = (r.stage == btp_pkg::STAGE_EXECUTE_TWO) ? `BTP_PEN_COMP : `BTP_PEN_INT;
    if ((r.taken && r.target_cross) || (!r.taken && r.seq_cross)) res_cost += `BTP_PEN_CROSS;
  endfunction
  task automatic lookup(input logic [21:0] a, input logic eh, input logic [21:0] et);
    @(posedge clk);
    restart <= 1'b1;
    restart_addr <= a;
    @(posedge clk);
    restart <= 1'b0;
    fetch_stage_one_valid <= 1'b1;
    #1 chk(fetch_stage_one_hit, eh, "hit");
    if (eh) chk(hit_target, et, "hit target");
    if (eh) chk({hit_cjump, hit_iret}, {et == cjump_reg, 1'b0}, "hit kind");
    @(posedge clk);
    fetch_stage_one_valid <= 1'b0;
    #1 chk(fetch_addr, eh ? et : a + `BTP_QW_STEP, "fetch addr");
  endtask
  task automatic fire(input btp_pkg::btp_decode_type d, input btp_pkg::btp_resolve_type r,
                      input logic er, input logic [2:0] ed, input logic [21:0] ea);
    int k;
    @(posedge clk);
    br <= d;
    rq <= r;
    @(posedge clk);
    br <= '0;
    rq <= '0;
    #1 chk(redirect, er, "redirect");
    chk(discard_cycles, er ? ed : 3'h0, "discard cycles");
    if (er) chk(fetch_addr, ea, "redirect addr");
    for (k = 0; k < 9 && fetch_go !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(k, er ? ed : 3'h0, "stall cycles");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    logic [4:0] v;
    logic [21:0] t;
    btp_pkg::btp_resolve_type r;
    {rstn, invalidate_all, restart, fetch_stage_one_valid} = 4'h0;
    target_cache_enable = 1'b1;
    restart_addr = 22'h000000;
    cjump_reg = 22'h00ABC0;
    iret_reg = 22'h001230;
    noise = 49'h0AAAAAAAAAAAA;
    br = '0;
    rq = '0;
    cond_class = btp_pkg::COND_INTEGER;
    void'($urandom(54073));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      tg[i] = rnd_qw();
      lookup(qaddr(i + 1, 3), 1'b0, 22'h0);
      fire(mkbr(qaddr(i + 1, 3), tg[i], 1'b0, 1'b0, i[0]), '0, 1'b1, 3'h2 + i[0], tg[i]);
      lookup(qaddr(i + 1, 3), 1'b1, tg[i]);
      fire(mkbr(qaddr(i + 1, 3), tg[i], 1'b0, 1'b0, 1'b0), '0, 1'b0, 3'h0, 22'h0);
    end
    lookup(qaddr(1, 3), 1'b0, 22'h0);
    lookup(qaddr(2, 3), 1'b1, tg[1]);
    lookup(qaddr(2, 4), 1'b0, 22'h0);
    t = rnd_qw();
    lookup(qaddr(9, 5), 1'b0, 22'h0);
    fire(mkbr(qaddr(9, 5), t, 1'b1, 1'b0, 1'b0), '0, 1'b0, 3'h0, t);
    lookup(qaddr(9, 5), 1'b0, 22'h0);
    lookup(qaddr(20, 7), 1'b0, 22'h0);
    fire(mkbr(qaddr(20, 7), cjump_reg, 1'b0, 1'b1, 1'b0), '0, 1'b1, 3'h2, cjump_reg);
    lookup(qaddr(20, 7), 1'b1, cjump_reg);
    @(posedge clk);
    cjump_reg <= t;
    fire(mkbr(qaddr(20, 7), t, 1'b0, 1'b1, 1'b0), '0, 1'b1, 3'h2, t);
    @(posedge clk);
    target_cache_enable <= 1'b0;
    lookup(qaddr(3, 3), 1'b0, 22'h0);
    fire(mkbr(qaddr(3, 3), tg[2], 1'b0, 1'b0, 1'b0), '0, 1'b1, 3'h2, tg[2]);
    @(posedge clk);
    target_cache_enable <= 1'b1;
    lookup(qaddr(3, 3), 1'b1, tg[2]);
    lookup(qaddr(6, 3), 1'b0, 22'h0);
    fire(mkbr(qaddr(6, 3), t, 1'b0, 1'b0, 1'b0), '0, 1'b1, 3'h2, t);
    lookup(qaddr(4, 3), 1'b0, 22'h0);
    lookup(qaddr(5, 3), 1'b1, tg[4]);
    @(posedge clk);
    invalidate_all <= 1'b1;
    @(posedge clk);
    invalidate_all <= 1'b0;
    lookup(qaddr(3, 3), 1'b0, 22'h0);
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      cond_class <= btp_pkg::btp_cond_type'(i);
      #1 chk(stage, i == 1 || i == 4, "resolve stage");
    end
    for (i = 0; i < 12; i++) begin
      v = (i < 4) ? {1'b1, 1'b1, i[1], i[0], ~i[0]} : 5'($urandom());
      r = '{1'b1, v[0], v[1], btp_pkg::btp_stage_type'(v[2]), rnd_qw(), rnd_qw(), v[3], v[4]};
      fire('0, r, v[0] != v[1], res_cost(r), v[1] ? r.target : r.seq_addr);
    end
    close_out();
  end
endmodule
